/* core/wcb_top.sv */
`timescale 1ns/100ps
`include "wcb_cfg.svh"
module wcb_top
  import wcb_pkg::*;
#(
  parameter int NUM_BUF = `WCB_NUM_BUF // 8, 10 or 12
)(
  input  wire logic                   clock,     // core clock
  input  wire logic                   rst_n,     // sync reset, active low
  input  wire logic                   ce,        // clock enable, freezes all
  input  wire logic                   st_valid,  // store offered
  output logic                        st_ready,  // store taken
  input  wire wcb_store_t             st_req,    // store payload
  input  wire logic                   flush_req, // level: drain buffers
  output logic                        ownership_read_request, // line read pending
  input  wire logic                   own_ready, // partner takes read
  output logic [`WCB_LINE_W-1:0]      own_line,  // line to read
  input  wire logic                   fill_valid,// returned line strobe
  input  wire wcb_fill_t              fill,      // returned line
  output logic                        wr_valid,  // bus write pending
  input  wire logic                   wr_ready,  // partner takes write
  output wcb_wr_t                     wr_out,    // bus write payload
  output logic                        idle       // no buffer in use
);

  localparam int IDX_W = $clog2(NUM_BUF);
  localparam int GATH  = `WCB_GATHER_CYC;

  // ****************************************************
  // state
  // ****************************************************
  logic [NUM_BUF-1:0]          vld_ff,  nxt_vld;
  logic [NUM_BUF-1:0]          need_ff, nxt_need;   // read not yet sent
  logic [NUM_BUF-1:0]          out_ff,  nxt_out;    // read sent, fill awaited
  logic [`WCB_LINE_W-1:0]      line_ff  [NUM_BUF];
  logic [`WCB_LINE_W-1:0]      nxt_line [NUM_BUF];
  wcb_mtype_t                  mt_ff    [NUM_BUF];
  wcb_mtype_t                  nxt_mt   [NUM_BUF];
  logic [3:0]                  gcnt_ff  [NUM_BUF];
  logic [3:0]                  nxt_gcnt [NUM_BUF];
  logic [NUM_BUF-1:0]          yng_ff   [NUM_BUF];  // [i][j]: j younger than i
  logic [NUM_BUF-1:0]          nxt_yng  [NUM_BUF];
  logic [`WCB_LINE_BITS-1:0]   data_ff  [NUM_BUF];
  logic [`WCB_LINE_BITS-1:0]   mg_data  [NUM_BUF];
  logic [`WCB_LINE_BYTES-1:0]  mask_ff  [NUM_BUF];
  logic [`WCB_LINE_BYTES-1:0]  mg_mask  [NUM_BUF];
  wcb_state_t                  st_ff,   nxt_st;
  logic [IDX_W-1:0]            ev_ff,   nxt_ev;
  logic [2:0]                  ch_ff,   nxt_ch;
  logic                        wrv_ff,  nxt_wrv;
  wcb_wr_t                     wro_ff,  nxt_wro;
  logic                        rfv_ff,  nxt_rfv;
  logic [`WCB_LINE_W-1:0]      rfl_ff,  nxt_rfl;

  // ****************************************************
  // decode helpers
  // ****************************************************
  function automatic logic [IDX_W-1:0] pick(input logic [NUM_BUF-1:0] v);
    pick = '0;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (v[i]) pick = IDX_W'(i);
    end
  endfunction

  function automatic logic [NUM_BUF-1:0] line_match(input logic [`WCB_LINE_W-1:0] ln,
                                                    input logic [NUM_BUF-1:0]     sel);
    line_match = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      line_match[i] = sel[i] && (line_ff[i] == ln);
    end
  endfunction

  // next chunk at or after 'from' holding written bytes
  function automatic logic [3:0] next_chunk(input logic [`WCB_LINE_BYTES-1:0] m,
                                            input logic [3:0]                 from);
    next_chunk = 4'h8;
    for (int c = `WCB_CHUNKS - 1; c >= 0; c--) begin
      if (c >= int'(from) && |m[c * `WCB_CHUNK_BYTES +: `WCB_CHUNK_BYTES]) next_chunk = 4'(c);
    end
  endfunction

  function automatic logic [`WCB_LINE_BYTES-1:0] chunk_be(input logic [`WCB_LINE_BYTES-1:0] m,
                                                          input logic [2:0]                 c);
    chunk_be = m & ({{(`WCB_LINE_BYTES - `WCB_CHUNK_BYTES){1'b0}}, 8'hff} << (int'(c) * 8));
  endfunction

  // ****************************************************
  // store and fill decode
  // ****************************************************
  logic [`WCB_LINE_W-1:0] st_line;
  logic [NUM_BUF-1:0]     st_hit, fill_hit, oldest, blk_vec, ev_cand, own_cand, alloc_vec;
  logic [IDX_W-1:0]       hit_idx, free_idx, old_idx;
  logic                   blocked, busy_hit, st_fire, full_press;

  assign st_line  = st_req.addr[`WCB_ADDR_W-1:`WCB_OFF_BITS];
  always_comb st_hit   = line_match(st_line, vld_ff);
  always_comb fill_hit = line_match(fill.line, out_ff) & {NUM_BUF{fill_valid & ce}};
  assign hit_idx  = pick(st_hit);
  assign free_idx = pick(~vld_ff);
  assign old_idx  = pick(oldest);

  // oldest: no valid entry is older; held stores see younger reads
  always_comb begin
    for (int i = 0; i < NUM_BUF; i++) begin
      oldest[i] = vld_ff[i];
      blk_vec[i] = vld_ff[i] && yng_ff[hit_idx][i] && (need_ff[i] || out_ff[i]);
      for (int j = 0; j < NUM_BUF; j++) begin
        if (vld_ff[j] && yng_ff[j][i]) oldest[i] = 1'b0;
      end
    end
  end

  assign blocked    = |blk_vec;
  assign busy_hit   = ev_cand[hit_idx] || ((st_ff != WCB_S_IDLE) && (ev_ff == hit_idx)); // line may be leaving
  assign full_press = st_valid && !(|st_hit) && (&vld_ff);
  // every store type is taken only into a buffer
  assign st_ready   = ce && ((|st_hit) ? (!blocked && !busy_hit) : !(&vld_ff));
  assign st_fire    = st_valid && st_ready;
  assign alloc_vec  = (st_fire && !(|st_hit)) ? (NUM_BUF'(1) << free_idx) : '0;

  // lines with no read pending or outstanding: complete ones, the oldest under pressure, or all on flush
  always_comb begin
    for (int i = 0; i < NUM_BUF; i++) begin
      ev_cand[i]  = vld_ff[i] && !need_ff[i] && !out_ff[i] &&
                    ((&mask_ff[i]) || (full_press && oldest[i]) || flush_req);
      own_cand[i] = vld_ff[i] && need_ff[i] && (int'(gcnt_ff[i]) >= GATH);
    end
  end

  // ****************************************************
  // per-buffer byte merge
  // ****************************************************
  generate
    for (genvar g = 0; g < NUM_BUF; g++) begin : g_buf
      wcb_line_merge u_merge (
        .cur_data  (data_ff[g]),
        .cur_mask  (alloc_vec[g] ? '0 : mask_ff[g]),
        .st_en     (st_fire && (st_hit[g] || alloc_vec[g])),
        .st_chunk  (st_req.addr[`WCB_OFF_BITS-1:3]),
        .st_be     (st_req.be),
        .st_data   (st_req.data),
        .fill_en   (fill_hit[g]),
        .fill_data (fill.data),
        .nxt_data  (mg_data[g]),
        .nxt_mask  (mg_mask[g])
      );

      // stored bytes survive a fill and the line ends complete
      AST_FILL_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
        (fill_hit[g] && !st_fire) |=> (&mask_ff[g]) &&
        ((data_ff[g] & $past(mask_bits(mask_ff[g]))) == ($past(data_ff[g]) & $past(mask_bits(mask_ff[g])))))
        else $error("stored bytes lost on fill");
    end
  endgenerate

  function automatic logic [`WCB_LINE_BITS-1:0] mask_bits(input logic [`WCB_LINE_BYTES-1:0] m);
    for (int i = 0; i < `WCB_LINE_BYTES; i++) mask_bits[i * 8 +: 8] = {8{m[i]}};
  endfunction

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic [3:0] nc;
    nc       = 4'h8;
    nxt_vld  = vld_ff;
    nxt_need = need_ff;
    nxt_out  = out_ff & ~fill_hit;
    nxt_line = line_ff;
    nxt_mt   = mt_ff;
    nxt_gcnt = gcnt_ff;
    nxt_yng  = yng_ff;
    nxt_st   = st_ff;
    nxt_ev   = ev_ff;
    nxt_ch   = ch_ff;
    nxt_wrv  = wrv_ff;
    nxt_wro  = wro_ff;
    nxt_rfv  = rfv_ff;
    nxt_rfl  = rfl_ff;
    // gather window before the line read leaves
    for (int i = 0; i < NUM_BUF; i++) begin
      if (need_ff[i] && int'(gcnt_ff[i]) < GATH) nxt_gcnt[i] = gcnt_ff[i] + 4'h1;
    end
    // allocate a free buffer and make it youngest
    if (|alloc_vec) begin
      nxt_vld[free_idx]  = 1'b1;
      nxt_line[free_idx] = st_line;
      nxt_mt[free_idx]   = st_req.mtype;
      nxt_need[free_idx] = (st_req.mtype == writeback_memory_type);
      nxt_out[free_idx]  = 1'b0;
      nxt_gcnt[free_idx] = 4'h0;
      nxt_yng[free_idx]  = '0;
      for (int i = 0; i < NUM_BUF; i++) begin
        if (i != int'(free_idx)) nxt_yng[i][free_idx] = 1'b1;
      end
    end
    // ownership read handshake
    if (rfv_ff && own_ready) begin
      nxt_rfv = 1'b0;
    end else if (!rfv_ff && (|own_cand)) begin
      nxt_rfv                = 1'b1;
      nxt_rfl                = line_ff[pick(own_cand)];
      nxt_need[pick(own_cand)] = 1'b0;
      nxt_out[pick(own_cand)]  = 1'b1;
    end
    // write-out sequencer
    case (st_ff)
      WCB_S_IDLE: begin
        if (|ev_cand) begin
          nxt_ev       = (full_press && ev_cand[old_idx]) ? old_idx : pick(ev_cand);
          nxt_wrv      = 1'b1;
          nxt_wro.line = line_ff[nxt_ev];
          nxt_wro.data = data_ff[nxt_ev];
          if (&mask_ff[nxt_ev]) begin
            nxt_st      = WCB_S_FULL;
            nxt_wro.full = 1'b1;
            nxt_wro.be   = '1;
          end else begin
            nc           = next_chunk(mask_ff[nxt_ev], 4'h0);
            nxt_st       = WCB_S_PART;
            nxt_ch       = nc[2:0];
            nxt_wro.full = 1'b0;
            nxt_wro.be   = chunk_be(mask_ff[nxt_ev], nc[2:0]);
          end
        end
      end
      WCB_S_FULL: begin
        if (wr_ready) begin
          nxt_wrv        = 1'b0;
          nxt_vld[ev_ff] = 1'b0;
          nxt_st         = WCB_S_IDLE;
        end
      end
      WCB_S_PART: begin
        if (wr_ready) begin
          nc = next_chunk(mask_ff[ev_ff], {1'b0, ch_ff} + 4'h1);
          if (nc[3]) begin
            nxt_wrv        = 1'b0;
            nxt_vld[ev_ff] = 1'b0;
            nxt_st         = WCB_S_IDLE;
          end else begin
            nxt_ch     = nc[2:0];
            nxt_wro.be = chunk_be(mask_ff[ev_ff], nc[2:0]);
          end
        end
      end
      default: begin
        nxt_st  = WCB_S_IDLE;
        nxt_wrv = 1'b0;
      end
    endcase
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vld_ff  <= '0;
      need_ff <= '0;
      out_ff  <= '0;
      st_ff   <= WCB_S_IDLE;
      ev_ff   <= '0;
      ch_ff   <= 3'h0;
      wrv_ff  <= 1'b0;
      wro_ff  <= '0;
      rfv_ff  <= 1'b0;
      rfl_ff  <= '0;
      for (int i = 0; i < NUM_BUF; i++) begin
        line_ff[i] <= '0;
        mt_ff[i]   <= writeback_memory_type;
        gcnt_ff[i] <= 4'h0;
        yng_ff[i]  <= '0;
        data_ff[i] <= '0;
        mask_ff[i] <= '0;
      end
    end else if (ce) begin
      vld_ff  <= nxt_vld;
      need_ff <= nxt_need;
      out_ff  <= nxt_out;
      line_ff <= nxt_line;
      mt_ff   <= nxt_mt;
      gcnt_ff <= nxt_gcnt;
      yng_ff  <= nxt_yng;
      data_ff <= mg_data;
      mask_ff <= mg_mask;
      st_ff   <= nxt_st;
      ev_ff   <= nxt_ev;
      ch_ff   <= nxt_ch;
      wrv_ff  <= nxt_wrv;
      wro_ff  <= nxt_wro;
      rfv_ff  <= nxt_rfv;
      rfl_ff  <= nxt_rfl;
    end
  end

  // outputs
  assign ownership_read_request = rfv_ff;
  assign own_line = rfl_ff;
  assign wr_valid = wrv_ff;
  assign wr_out   = wro_ff;
  assign idle     = !(|vld_ff) && (st_ff == WCB_S_IDLE);

  // ****************************************************
  // checks
  // ****************************************************
  AST_OWN_GATHER: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(ownership_read_request) |-> (|line_match(own_line, $past(vld_ff, GATH + 1))))
    else $error("ownership read before gather window");
  AST_FULL_ONE: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_valid && wr_out.full) |-> (&wr_out.be) && (st_ff == WCB_S_FULL))
    else $error("full write without all bytes");
  AST_PART_SPLIT: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_valid && !wr_out.full) |-> !(&wr_out.be) && ((wr_out.be & ~chunk_be('1, ch_ff)) == '0))
    else $error("partial write spans more than one chunk");
  AST_CACHED_OWN: assert property (@(posedge clock) disable iff (!rst_n)
    (|alloc_vec && st_req.mtype == writeback_memory_type) |=> need_ff[$past(free_idx)])
    else $error("cacheable allocation without ownership read");
  AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (st_valid && (|st_hit) && blocked) |-> !st_ready)
    else $error("store passed a younger pending ownership read");
  AST_COMB_NO_OWN: assert property (@(posedge clock) disable iff (!rst_n)
    (|alloc_vec && st_req.mtype == combining_memory_type) |=> !need_ff[$past(free_idx)] &&
    (mt_ff[$past(free_idx)] == combining_memory_type))
    else $error("combining store raised an ownership read");
  AST_LINE_ALIGN: assert property (@(posedge clock) disable iff (!rst_n)
    st_fire |=> (|line_match($past(st_req.addr[`WCB_ADDR_W-1:`WCB_OFF_BITS]), vld_ff)))
    else $error("store line not held in a buffer");
  AST_EVICT_OLD: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && st_ff == WCB_S_IDLE && full_press && ev_cand[old_idx]) |=> (ev_ff == $past(old_idx)) && wr_valid)
    else $error("eviction did not pick the oldest buffer");
  AST_NO_ALLOC_FULL: assert property (@(posedge clock) disable iff (!rst_n)
    (&vld_ff && st_valid && !(|st_hit)) |-> !st_ready)
    else $error("store allocated while all buffers held");
endmodule

/* core/wcb_cfg.svh */
`ifndef WCB_CFG_SVH
`define WCB_CFG_SVH

// ****************************************************
// geometry
// ****************************************************
`define WCB_NUM_BUF     12
`define WCB_ADDR_W      32
`define WCB_OFF_BITS    6
`define WCB_LINE_W      26
`define WCB_LINE_BYTES  64
`define WCB_LINE_BITS   512
`define WCB_CHUNKS      8
`define WCB_CHUNK_BYTES 8
`define WCB_CHUNK_BITS  64

// ****************************************************
// timing
// ****************************************************
`define WCB_CLK_MHZ     125
`define WCB_GATHER_NS   24
`define WCB_GATHER_CYC  ((`WCB_GATHER_NS * `WCB_CLK_MHZ + 999) / 1000)

`endif

/* core/wcb_pkg.sv */
`include "wcb_cfg.svh"
package wcb_pkg;

  // memory type of a store target
  typedef enum logic [1:0] {
    writeback_memory_type = 2'h0,
    uncached_memory_type  = 2'h1,
    combining_memory_type = 2'h2
  } wcb_mtype_t;

  // one store from the core, 8 bytes at addr[5:3]
  typedef struct packed {
    logic [`WCB_ADDR_W-1:0]      addr;
    wcb_mtype_t                  mtype;
    logic [`WCB_CHUNK_BYTES-1:0] be;
    logic [`WCB_CHUNK_BITS-1:0]  data;
  } wcb_store_t;

  // line data returned for an ownership read
  typedef struct packed {
    logic [`WCB_LINE_W-1:0]    line;
    logic [`WCB_LINE_BITS-1:0] data;
  } wcb_fill_t;

  // bus write of a whole or partial line
  typedef struct packed {
    logic [`WCB_LINE_W-1:0]     line;
    logic                       full;
    logic [`WCB_LINE_BYTES-1:0] be;
    logic [`WCB_LINE_BITS-1:0]  data;
  } wcb_wr_t;

  // write-out sequencer
  typedef enum logic [2:0] {
    WCB_S_IDLE = 3'b001,
    WCB_S_FULL = 3'b010,
    WCB_S_PART = 3'b100
  } wcb_state_t;

endpackage

/* core/wcb_line_merge.sv */
`timescale 1ns/100ps
`include "wcb_cfg.svh"
module wcb_line_merge
  import wcb_pkg::*;
(
  input  wire logic [`WCB_LINE_BITS-1:0]   cur_data,  // held line bytes
  input  wire logic [`WCB_LINE_BYTES-1:0]  cur_mask,  // written byte flags
  input  wire logic                        st_en,     // store lands here
  input  wire logic [2:0]                  st_chunk,  // 8-byte slot in line
  input  wire logic [`WCB_CHUNK_BYTES-1:0] st_be,     // store byte enables
  input  wire logic [`WCB_CHUNK_BITS-1:0]  st_data,   // store bytes
  input  wire logic                        fill_en,   // returned line lands here
  input  wire logic [`WCB_LINE_BITS-1:0]   fill_data, // returned line bytes
  output logic      [`WCB_LINE_BITS-1:0]   nxt_data,  // merged line
  output logic      [`WCB_LINE_BYTES-1:0]  nxt_mask   // merged flags
);

  // ****************************************************
  // store first, then fill the gaps
  // ****************************************************
  always_comb begin
    nxt_data = cur_data;
    nxt_mask = cur_mask;
    if (st_en) begin
      for (int b = 0; b < `WCB_CHUNK_BYTES; b++) begin
        if (st_be[b]) begin
          nxt_data[(int'(st_chunk) * `WCB_CHUNK_BYTES + b) * 8 +: 8] = st_data[b * 8 +: 8];
          nxt_mask[int'(st_chunk) * `WCB_CHUNK_BYTES + b] = 1'b1;
        end
      end
    end
    if (fill_en) begin
      for (int i = 0; i < `WCB_LINE_BYTES; i++) begin
        if (!nxt_mask[i]) begin
          nxt_data[i * 8 +: 8] = fill_data[i * 8 +: 8];
        end
      end
      nxt_mask = '1;
    end
  end

endmodule

/* testbench/wcb_outer_model.sv */
`timescale 1ns/100ps
`include "wcb_cfg.svh"
module wcb_outer_model
  import wcb_pkg::*;
#(
  parameter int LAT = 3 // cycles counted before return; line returns LAT + 1 cycles after read taken
)(
  input  wire logic                    clock,                  // core clock
  input  wire logic                    rst_n,                  // sync reset, active low
  input  wire logic                    stall,                  // hold back fills and writes
  input  wire logic                    ownership_read_request, // line read pending
  input  wire logic [`WCB_LINE_W-1:0]  own_line,               // line to read
  output logic                         own_ready,              // read taken
  output logic                         fill_valid,             // returned line strobe
  output wcb_fill_t                    fill,                   // returned line
  output logic                         wr_ready                // bus write taken
);
  logic [`WCB_LINE_W-1:0] pend_q[$];
  int                     wait_cnt;
  int                     i;

  // returned lines carry a fixed byte pattern
  initial begin
    own_ready  = 1'b0;
    fill_valid = 1'b0;
    wr_ready   = 1'b0;
    wait_cnt   = 0;
    fill.line  = '0;
    for (i = 0; i < 64; i++) begin
      fill.data[8*i+:8] = 8'ha5 ^ 8'(i);
    end
  end

  // reads queue up at the handshake edge
  always @(posedge clock) begin
    if (rst_n && ownership_read_request && own_ready) begin
      pend_q.push_back(own_line);
    end
  end

  // answers change only after the falling edge; idle data keeps toggling
  always @(negedge clock) begin
    own_ready  <= rst_n && ownership_read_request;
    wr_ready   <= rst_n && !stall;
    fill_valid <= 1'b0;
    fill.data  <= ~fill.data;
    if (pend_q.size() != 0 && !stall) begin
      if (wait_cnt >= LAT) begin
        fill_valid <= 1'b1;
        fill.line  <= pend_q.pop_front();
        for (i = 0; i < 64; i++) begin
          fill.data[8*i+:8] <= 8'ha5 ^ 8'(i);
        end
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule

/* testbench/test_write_combining_buffers.sv */
`timescale 1ns/100ps
`include "wcb_cfg.svh"
module test_write_combining_buffers;
  import wcb_pkg::*;
  localparam int NB = 8;
  logic                   clock, rst_n, st_valid, st_ready, flush_req, stall, ce;
  logic                   ownership_read_request, own_ready, fill_valid;
  logic                   wr_valid, wr_ready, idle;
  logic [`WCB_LINE_W-1:0] own_line, own_seen;
  wcb_store_t             st_req;
  wcb_fill_t              fill;
  wcb_wr_t                wr_out;
  wcb_wr_t                wq[$];
  int                     n_fail, samples_checked, n_own;

  wcb_top #(.NUM_BUF(NB)) dut (.clock(clock), .rst_n(rst_n), .ce(ce), .st_valid(st_valid),
    .st_ready(st_ready), .st_req(st_req), .flush_req(flush_req),
    .ownership_read_request(ownership_read_request), .own_ready(own_ready), .own_line(own_line),
    .fill_valid(fill_valid), .fill(fill), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_out(wr_out), .idle(idle));

  wcb_outer_model outer (.clock(clock), .rst_n(rst_n), .stall(stall),
    .ownership_read_request(ownership_read_request), .own_line(own_line), .own_ready(own_ready),
    .fill_valid(fill_valid), .fill(fill), .wr_ready(wr_ready));

  // ****************************************************
  // clock and bus monitor
  // ****************************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // record every read and write handshake
  always @(posedge clock) begin
    if (rst_n && wr_valid && wr_ready) wq.push_back(wr_out);
    if (rst_n && ownership_read_request && own_ready) begin
      n_own++;
      own_seen = own_line;
    end
  end

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [511:0] seen, input logic [511:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // offer one store and hold it until taken
  task automatic put(input logic [31:0] a, input wcb_mtype_t mt, input logic [7:0] be, input logic [63:0] d);
    int k;
    @(negedge clock);
    st_req   = '{addr: a, mtype: mt, be: be, data: d};
    st_valid = 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clock);
      if (st_ready === 1'b1) break;
    end
    if (k == 200) begin
      n_fail++;
      test_done;
    end
    @(negedge clock);
    st_valid = 1'b0;
  endtask

  // wait until every buffer has drained
  task automatic settle;
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clock);
      if (idle === 1'b1 && wr_valid === 1'b0) break;
    end
    if (k == 300) begin
      n_fail++;
      test_done;
    end
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  // clock enable low: a store is refused and nothing moves
  task automatic sc_freeze;
    int k;
    @(negedge clock);
    ce       = 1'b0;
    st_req   = '{addr: 32'h0000_a000, mtype: combining_memory_type, be: 8'h01, data: 64'h7};
    st_valid = 1'b1;
    for (k = 0; k < 3; k++) begin
      @(posedge clock);
      chk("frozen ready", st_ready, 1'b0);
    end
    @(negedge clock);
    st_valid = 1'b0;
    ce       = 1'b1;
    chk("frozen idle", idle, 1'b1);
  endtask

  // cacheable stores gather, then the fill merges around them
  task automatic sc_gather_merge;
    logic [511:0] exp;
    int           i;
    wq.delete();
    n_own = 0;
    for (i = 0; i < 64; i++) exp[8*i+:8] = 8'ha5 ^ 8'(i);
    exp[64+:64]  = 64'h1111_2222_3333_4444;
    exp[384+:32] = 32'hdead_beef;
    put(32'h0000_4008, writeback_memory_type, 8'hff, 64'h1111_2222_3333_4444);
    put(32'h0000_4035, writeback_memory_type, 8'h0f, 64'h0000_0000_dead_beef);
    chk("read before gather", n_own, 0);
    settle;
    chk("read count", n_own, 1);
    chk("read line", own_seen, 26'h000_0100);
    chk("write count", wq.size(), 1);
    chk("write line", wq[0].line, 26'h000_0100);
    chk("write full", wq[0].full, 1'b1);
    chk("write data", wq[0].data, exp);
  endtask

  // an uncached line written in parts leaves as one full write
  task automatic sc_uncached_full;
    logic [511:0] exp;
    int           c;
    wq.delete();
    n_own = 0;
    for (c = 0; c < 8; c++) begin
      exp[64*c+:64] = {8{8'(c + 16)}};
      put(32'h0000_6000 + 32'(8 * c), uncached_memory_type, 8'hff, {8{8'(c + 16)}});
    end
    settle;
    chk("uncached reads", n_own, 0);
    chk("uncached writes", wq.size(), 1);
    chk("uncached full", wq[0].full, 1'b1);
    chk("uncached be", wq[0].be, {64{1'b1}});
    chk("uncached data", wq[0].data, exp);
  endtask

  // 63 bytes flushed leave as partial writes
  task automatic sc_partial63;
    int c;
    wq.delete();
    n_own = 0;
    for (c = 0; c < 8; c++) begin
      put(32'h0000_7000 + 32'(8 * c), combining_memory_type, (c == 7) ? 8'h7f : 8'hff, 64'h0);
    end
    @(negedge clock);
    flush_req = 1'b1;
    settle;
    flush_req = 1'b0;
    chk("combining reads", n_own, 0);
    chk("partial count", wq.size(), 8);
    for (c = 0; c < 8 && c < wq.size(); c++) begin
      chk("partial full", wq[c].full, 1'b0);
      chk("partial be", wq[c].be, 64'((c == 7) ? 8'h7f : 8'hff) << (8 * c));
    end
  endtask

  // a younger read holds stores to the older line; combining does not
  task automatic sc_order;
    int k;
    stall = 1'b1;
    put(32'h0000_9000, combining_memory_type, 8'h01, 64'h1);
    put(32'h0000_9040, combining_memory_type, 8'h01, 64'h2);
    @(negedge clock);
    st_req   = '{addr: 32'h0000_9008, mtype: combining_memory_type, be: 8'h01, data: 64'h3};
    st_valid = 1'b1;
    @(posedge clock);
    chk("combining not held", st_ready, 1'b1);
    @(negedge clock);
    st_valid = 1'b0;
    put(32'h0000_5000, writeback_memory_type, 8'h01, 64'h4);
    put(32'h0000_5040, writeback_memory_type, 8'h01, 64'h5);
    repeat (12) @(negedge clock);
    st_req   = '{addr: 32'h0000_5008, mtype: writeback_memory_type, be: 8'h01, data: 64'h6};
    st_valid = 1'b1;
    for (k = 0; k < 4; k++) begin
      @(posedge clock);
      chk("older line held", st_ready, 1'b0);
    end
    @(negedge clock);
    stall = 1'b0;
    put(32'h0000_5008, writeback_memory_type, 8'h01, 64'h6);
    flush_req = 1'b1;
    settle;
    flush_req = 1'b0;
  endtask

  // one line more than there are buffers evicts the oldest first
  task automatic sc_evict;
    int k;
    wq.delete();
    for (k = 0; k <= NB; k++) begin
      put(32'h0000_8000 + 32'(64 * k), combining_memory_type, 8'h01, 64'(k));
    end
    chk("evict happened", wq.size() >= 1, 1'b1);
    chk("evict oldest", wq[0].line, 26'h000_0200);
    flush_req = 1'b1;
    settle;
    flush_req = 1'b0;
    chk("evict total", wq.size(), NB + 1);
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    rst_n = 1'b0;
    st_valid = 1'b0;
    st_req = '0;
    flush_req = 1'b0;
    stall = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    n_own = 0;
    ce = 1'b1;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    chk("idle after reset", idle, 1'b1);
    sc_freeze;
    sc_gather_merge;
    sc_uncached_full;
    sc_partial63;
    sc_order;
    sc_evict;
    test_done;
  end
endmodule
